// file: dfm_capture_model.sv
`default_nettype none
module dfm_capture_model (
	input wire logic pclk,
	input wire logic strobe,
	input wire logic [13:0] word,
	input wire logic flag,
	input wire logic oe_n,
	output logic [14:0] cap_hi_ff,
	output logic [14:0] cap_lo_ff
);
	timeunit 1ns;
	timeprecision 1ns;
	logic [14:0] nxt_cap_hi;
	logic [14:0] nxt_cap_lo;
	// latch flag and word in each strobe phase, only while bus is driven
	always_comb begin
		nxt_cap_hi = cap_hi_ff;
		nxt_cap_lo = cap_lo_ff;
		if (!oe_n && strobe) nxt_cap_hi = {flag, word};
		if (!oe_n && !strobe) nxt_cap_lo = {flag, word};
	end
	// capture registers, last value of each phase wins
	always_ff @(posedge pclk) begin
		cap_hi_ff <= nxt_cap_hi;
		cap_lo_ff <= nxt_cap_lo;
	end
endmodule : dfm_capture_model
`default_nettype wire

// file: dfm_cfg.svh
`ifndef DFM_CFG_SVH
`define DFM_CFG_SVH
// register map
`define DFM_CTRL_OFS 12'h000
`define DFM_STAT_OFS 12'h004
`define DFM_CTRL_RST 2'h0
`define DFM_FMT_LSB 0
`define DFM_STAT_DCS_LOCK 6
`define DFM_STAT_DCS_ON 7
`define DFM_STAT_TWOS 8
// sample coding
`define DFM_MID 14'h2000
`define DFM_MAX 14'h3FFF
`define DFM_MIN 14'h0000
`define DFM_TC_MAX 14'h1FFF
`define DFM_POS_LIM 16'sh1FFF
`define DFM_NEG_LIM 16'shE000
// pipeline depth in sample clocks
`define DFM_LAT 5
// timing
`define DFM_CLK_PERIOD_NS 100
`define DFM_NAP_CYC 7'd100
`define DFM_LOCK_CYC 7'd100
`define DFM_SLEEP_SETTLE_NS 2000000
`define DFM_SLEEP_SETTLE_CYC (`DFM_SLEEP_SETTLE_NS / `DFM_CLK_PERIOD_NS)
`define DFM_CLK_STOP_NS 100000
`define DFM_CLK_STOP_CYC (`DFM_CLK_STOP_NS / `DFM_CLK_PERIOD_NS)
`endif

// file: dfm_output_stage.sv
// Functional notes
// - offset binary: zero mid, extremes all ones/zeros
// - two's complement is offset binary, MSB inverted
// - out of range clamps to end code
// - range flag high only when clamped
// - four-level format select decoded
// - one format setting serves both channels
// - output enable high tristates data and flag
// - separate output enable per bus
// - power-down low means normal conversion
// - power-down plus enable high gives sleep
// - nap keeps reference, 100 sample clock recovery
// - nap and sleep tristate word and flag of the bus carrying that channel
// - channel power set by own pins only
// - swap high: A to bus A, B to B
// - swap low: A to bus B, B to A
// - stabilizer relocks after 100 clocks
//
// Our own choices: the APB register port and the register addresses.
`include "dfm_cfg.svh"
`default_nettype none
module dfm_output_stage #(
	parameter int SLEEP_SETTLE_CYC = `DFM_SLEEP_SETTLE_CYC
) (
	input wire logic pclk,
	input wire logic presetn,
	input wire logic [11:0] paddr,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	input wire logic sample_clock_chan_a,
	input wire logic sample_clock_chan_b,
	input wire logic [15:0] conv_result_chan_a,
	input wire logic [15:0] conv_result_chan_b,
	input wire logic output_drive_enable_n_chan_a,
	input wire logic output_drive_enable_n_chan_b,
	input wire logic power_down_select_chan_a,
	input wire logic power_down_select_chan_b,
	input wire logic bus_swap_select,
	output logic [13:0] output_bus_a_word,
	output logic range_exceeded_flag_bus_a,
	output logic output_bus_a_oe_n,
	output logic [13:0] output_bus_b_word,
	output logic range_exceeded_flag_bus_b,
	output logic output_bus_b_oe_n
);
	localparam int NCH = 2;
	localparam int LAT = `DFM_LAT;
	default clocking cb @(posedge pclk); endclocking
	default disable iff (!presetn);

	// per-channel pins gathered by index, 0 is A
	logic [NCH-1:0] smp_clk;
	logic [NCH-1:0] oe_n_pin;
	logic [NCH-1:0] pd_pin;
	logic signed [15:0] conv [NCH];
	logic [14:0] chan_word [NCH];
	logic [NCH-1:0] chan_drive;
	logic [NCH-1:0] chan_strobe;
	dfm_pkg::dfm_pwr_type chan_pwr [NCH];
	assign smp_clk = {sample_clock_chan_b, sample_clock_chan_a};
	assign oe_n_pin = {output_drive_enable_n_chan_b,
		output_drive_enable_n_chan_a};
	assign pd_pin = {power_down_select_chan_b, power_down_select_chan_a};
	assign conv[0] = conv_result_chan_a;
	assign conv[1] = conv_result_chan_b;

	// clamp, flag and code one sample: {flag, word}
	function automatic logic [14:0] code_sample(
		input logic signed [15:0] v,
		input logic tc
	);
		logic [13:0] w;
		logic ovr;
		ovr = 1'b0;
		w = v[13:0] ^ `DFM_MID;
		if (v > `DFM_POS_LIM) begin
			w = `DFM_MAX;
			ovr = 1'b1;
		end else if (v < `DFM_NEG_LIM) begin
			w = `DFM_MIN;
			ovr = 1'b1;
		end
		if (tc) begin
			w = w ^ `DFM_MID;
		end
		code_sample = {ovr, w};
	endfunction : code_sample

	// register select: 1 control, 2 status, 0 unmapped
	function automatic logic [1:0] reg_sel(input logic [11:0] a);
		if (a == `DFM_CTRL_OFS) begin
			reg_sel = 2'h1;
		end else if (a == `DFM_STAT_OFS) begin
			reg_sel = 2'h2;
		end else begin
			reg_sel = 2'h0;
		end
	endfunction : reg_sel

	// format decode, shared by both channels
	dfm_pkg::dfm_fmt_type fmt_ff, nxt_fmt;
	logic twos;
	logic dcs_on;
	assign twos = fmt_ff[1];
	assign dcs_on = fmt_ff[1] ^ fmt_ff[0];

	// stabilizer lock tracking on the channel A sample clock
	logic dcs_lock_ff, nxt_dcs_lock;
	logic [6:0] lock_cnt_ff, nxt_lock_cnt;
	logic [9:0] idle_cnt_ff, nxt_idle_cnt;
	always_comb begin
		nxt_dcs_lock = dcs_lock_ff;
		nxt_lock_cnt = lock_cnt_ff;
		nxt_idle_cnt = idle_cnt_ff;
		if (!dcs_on) begin
			nxt_dcs_lock = 1'b0;
			nxt_lock_cnt = 7'h00;
			nxt_idle_cnt = 10'h000;
		end else if (chan_strobe[0]) begin
			nxt_idle_cnt = 10'h000;
			if (!dcs_lock_ff) begin
				if (lock_cnt_ff == `DFM_LOCK_CYC - 7'd1) begin
					nxt_dcs_lock = 1'b1;
				end else begin
					nxt_lock_cnt = lock_cnt_ff + 7'd1;
				end
			end
		end else if (idle_cnt_ff == 10'(`DFM_CLK_STOP_CYC - 1)) begin
			nxt_dcs_lock = 1'b0;
			nxt_lock_cnt = 7'h00;
		end else begin
			nxt_idle_cnt = idle_cnt_ff + 10'd1;
		end
	end
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			dcs_lock_ff <= 1'b0;
			lock_cnt_ff <= 7'h00;
			idle_cnt_ff <= 10'h000;
		end else begin
			dcs_lock_ff <= nxt_dcs_lock;
			lock_cnt_ff <= nxt_lock_cnt;
			idle_cnt_ff <= nxt_idle_cnt;
		end
	end

	// apb slave: answer in the first access cycle
	logic [31:0] prdata_ff, nxt_prdata;
	logic pready_ff, nxt_pready;
	logic pslverr_ff, nxt_pslverr;
	logic [31:0] status_word;
	assign status_word = {23'h000000, twos, dcs_on, dcs_lock_ff,
		chan_pwr[1], chan_pwr[0]};
	always_comb begin
		nxt_fmt = fmt_ff;
		nxt_prdata = prdata_ff;
		nxt_pready = psel & ~penable;
		nxt_pslverr = 1'b0;
		if (psel && !penable) begin
			nxt_pslverr = (reg_sel(paddr) == 2'h0);
			if (reg_sel(paddr) == 2'h1) begin
				nxt_prdata = {30'h00000000, fmt_ff};
			end else if (reg_sel(paddr) == 2'h2) begin
				nxt_prdata = status_word;
			end else begin
				nxt_prdata = 32'h00000000;
			end
		end
		if (psel && penable && pready_ff && pwrite &&
			reg_sel(paddr) == 2'h1) begin
			nxt_fmt = dfm_pkg::dfm_fmt_type'(pwdata[`DFM_FMT_LSB +: 2]);
		end
	end
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			fmt_ff <= dfm_pkg::dfm_fmt_type'(`DFM_CTRL_RST);
			prdata_ff <= 32'h00000000;
			pready_ff <= 1'b0;
			pslverr_ff <= 1'b0;
		end else begin
			fmt_ff <= nxt_fmt;
			prdata_ff <= nxt_prdata;
			pready_ff <= nxt_pready;
			pslverr_ff <= nxt_pslverr;
		end
	end
	assign prdata = prdata_ff;
	assign pready = pready_ff;
	assign pslverr = pslverr_ff;

	// per-channel power state and conversion pipeline
	for (genvar c = 0; c < NCH; c++) begin : g_ch
		logic clk_prev_ff;
		dfm_pkg::dfm_pwr_type pwr_ff, nxt_pwr;
		logic [23:0] wake_ff, nxt_wake;
		logic [14:0] pipe_ff [LAT];
		logic [14:0] nxt_pipe [LAT];
		logic conv_on;
		assign chan_strobe[c] = smp_clk[c] & ~clk_prev_ff;
		assign conv_on = pwr_ff != dfm_pkg::ps_nap &&
			pwr_ff != dfm_pkg::ps_sleep;
		assign chan_drive[c] = conv_on;
		assign chan_word[c] = pipe_ff[LAT-1];
		assign chan_pwr[c] = pwr_ff;

		// power state from this channel's own pins only
		always_comb begin
			nxt_pwr = pwr_ff;
			nxt_wake = wake_ff;
			case (pwr_ff)
				dfm_pkg::ps_run: begin
					if (pd_pin[c]) begin
						nxt_pwr = oe_n_pin[c] ? dfm_pkg::ps_sleep
							: dfm_pkg::ps_nap;
					end
				end
				dfm_pkg::ps_nap: begin
					if (!pd_pin[c]) begin
						nxt_pwr = dfm_pkg::ps_wake_nap;
						nxt_wake = {17'h00000, `DFM_NAP_CYC};
					end else if (oe_n_pin[c]) begin
						nxt_pwr = dfm_pkg::ps_sleep;
					end
				end
				dfm_pkg::ps_sleep: begin
					if (!pd_pin[c]) begin
						nxt_pwr = dfm_pkg::ps_wake_sleep;
						nxt_wake = 24'(SLEEP_SETTLE_CYC);
					end
				end
				dfm_pkg::ps_wake_nap, dfm_pkg::ps_wake_sleep: begin
					if (pd_pin[c]) begin
						nxt_pwr = oe_n_pin[c] ? dfm_pkg::ps_sleep
							: dfm_pkg::ps_nap;
					end else if (wake_ff == 24'h000000) begin
						nxt_pwr = dfm_pkg::ps_run;
					end else if (pwr_ff == dfm_pkg::ps_wake_sleep ||
						chan_strobe[c]) begin
						nxt_wake = wake_ff - 24'h000001;
					end
				end
				default: begin
					nxt_pwr = dfm_pkg::ps_run;
				end
			endcase
		end

		// one coded word per sample clock rising edge, except in nap and sleep
		always_comb begin
			for (int i = 0; i < LAT; i++) begin
				nxt_pipe[i] = pipe_ff[i];
			end
			if (chan_strobe[c] && conv_on) begin
				nxt_pipe[0] = code_sample(conv[c], twos);
				for (int i = 1; i < LAT; i++) begin
					nxt_pipe[i] = pipe_ff[i-1];
				end
			end
		end
		always_ff @(posedge pclk or negedge presetn) begin
			if (!presetn) begin
				clk_prev_ff <= 1'b0;
				pwr_ff <= dfm_pkg::ps_run;
				wake_ff <= 24'h000000;
				for (int i = 0; i < LAT; i++) begin
					pipe_ff[i] <= 15'h0000;
				end
			end else begin
				clk_prev_ff <= smp_clk[c];
				pwr_ff <= nxt_pwr;
				wake_ff <= nxt_wake;
				for (int i = 0; i < LAT; i++) begin
					pipe_ff[i] <= nxt_pipe[i];
				end
			end
		end

		property p_ob_mid;
			chan_strobe[c] && conv_on && !twos && conv[c] == 16'sh0000
				|=> pipe_ff[0] == {1'b0, `DFM_MID};
		endproperty
		a_ob_mid: assert property (p_ob_mid)
			else $error("offset binary zero code wrong");
		property p_tc_max;
			chan_strobe[c] && conv_on && twos && conv[c] == `DFM_POS_LIM
				|=> pipe_ff[0] == {1'b0, `DFM_TC_MAX};
		endproperty
		a_tc_max: assert property (p_tc_max)
			else $error("two's complement full scale wrong");
		property p_clamp;
			chan_strobe[c] && conv_on && conv[c] > `DFM_POS_LIM
				|=> pipe_ff[0] ==
				{1'b1, $past(twos) ? `DFM_TC_MAX : `DFM_MAX};
		endproperty
		a_clamp: assert property (p_clamp)
			else $error("overrange not clamped");
		property p_flag_low;
			chan_strobe[c] && conv_on && conv[c] <= `DFM_POS_LIM &&
				conv[c] >= `DFM_NEG_LIM |=> !pipe_ff[0][14];
		endproperty
		a_flag_low: assert property (p_flag_low)
			else $error("range flag set for in-range sample");
		property p_sleep;
			pwr_ff == dfm_pkg::ps_run && pd_pin[c] && oe_n_pin[c]
				|=> pwr_ff == dfm_pkg::ps_sleep;
		endproperty
		a_sleep: assert property (p_sleep)
			else $error("sleep not entered");
		property p_nap_exit;
			pwr_ff == dfm_pkg::ps_nap && !pd_pin[c] |=>
				pwr_ff == dfm_pkg::ps_wake_nap && wake_ff == 24'd100;
		endproperty
		a_nap_exit: assert property (p_nap_exit)
			else $error("nap recovery count wrong");
		property p_run_hold;
			pwr_ff == dfm_pkg::ps_run && !pd_pin[c]
				|=> pwr_ff == dfm_pkg::ps_run && conv_on;
		endproperty
		a_run_hold: assert property (p_run_hold)
			else $error("channel left normal operation");
		c_nap_back: cover property (pwr_ff == dfm_pkg::ps_wake_nap
			##1 pwr_ff == dfm_pkg::ps_run);
		c_clamp: cover property (chan_strobe[c] && conv[c] < `DFM_NEG_LIM);
	end

	// output buses: routing, enable and registered drive
	logic [13:0] bus_word_ff [NCH];
	logic [NCH-1:0] bus_flag_ff;
	logic [NCH-1:0] bus_oe_n_ff;
	for (genvar b = 0; b < NCH; b++) begin : g_bus
		logic [13:0] nxt_word;
		logic nxt_flag;
		logic nxt_oe_n;
		int src;
		assign src = bus_swap_select ? b : NCH - 1 - b;
		always_comb begin
			nxt_oe_n = oe_n_pin[b] | ~chan_drive[src];
			nxt_word = nxt_oe_n ? 14'h0000 : chan_word[src][13:0];
			nxt_flag = ~nxt_oe_n & chan_word[src][14];
		end
		always_ff @(posedge pclk or negedge presetn) begin
			if (!presetn) begin
				bus_word_ff[b] <= 14'h0000;
				bus_flag_ff[b] <= 1'b0;
				bus_oe_n_ff[b] <= 1'b1;
			end else begin
				bus_word_ff[b] <= nxt_word;
				bus_flag_ff[b] <= nxt_flag;
				bus_oe_n_ff[b] <= nxt_oe_n;
			end
		end

		property p_swap_hi;
			bus_swap_select && !oe_n_pin[b] && chan_drive[b]
				|=> bus_word_ff[b] == $past(chan_word[b][13:0]);
		endproperty
		a_swap_hi: assert property (p_swap_hi)
			else $error("straight routing wrong");
		property p_swap_lo;
			!bus_swap_select && !oe_n_pin[b] && chan_drive[NCH-1-b]
				|=> bus_word_ff[b] == $past(chan_word[NCH-1-b][13:0]);
		endproperty
		a_swap_lo: assert property (p_swap_lo)
			else $error("swapped routing wrong");
		property p_oe;
			oe_n_pin[b] |=> bus_oe_n_ff[b] && !bus_flag_ff[b];
		endproperty
		a_oe: assert property (p_oe)
			else $error("bus driven while disabled");
		property p_pwr_hiz;
			bus_swap_select && !chan_drive[b] |=> bus_oe_n_ff[b];
		endproperty
		a_pwr_hiz: assert property (p_pwr_hiz)
			else $error("bus driven while channel powered down");
		c_interleave: cover property (bus_swap_select ##1
			!bus_swap_select ##1 bus_swap_select);
	end
	assign output_bus_a_word = bus_word_ff[0];
	assign range_exceeded_flag_bus_a = bus_flag_ff[0];
	assign output_bus_a_oe_n = bus_oe_n_ff[0];
	assign output_bus_b_word = bus_word_ff[1];
	assign range_exceeded_flag_bus_b = bus_flag_ff[1];
	assign output_bus_b_oe_n = bus_oe_n_ff[1];

	property p_dcs_off;
		!dcs_on |=> !dcs_lock_ff;
	endproperty
	a_dcs_off: assert property (p_dcs_off)
		else $error("stabilizer locked while off");
endmodule : dfm_output_stage
`default_nettype wire

// file: dfm_pkg.sv
`default_nettype none
package dfm_pkg;
	typedef enum logic [2:0] {
		ps_run = 3'b000,
		ps_nap = 3'b001,
		ps_sleep = 3'b010,
		ps_wake_nap = 3'b011,
		ps_wake_sleep = 3'b100
	} dfm_pwr_type;
	typedef enum logic [1:0] {
		fmt_ob_dcs_off = 2'b00,
		fmt_ob_dcs_on = 2'b01,
		fmt_tc_dcs_on = 2'b10,
		fmt_tc_dcs_off = 2'b11
	} dfm_fmt_type;
endpackage : dfm_pkg
`default_nettype wire

// file: dual_adc_output_format_mux_tb_top.sv
`default_nettype none
module dual_adc_output_format_mux_tb_top;
	timeunit 1ns;
	timeprecision 1ns;
	logic pclk, presetn, psel, penable, pwrite, pready, pslverr, e;
	logic sclk, swp, il, oa_n, ob_n, pda, pdb, fa, fb, boa_n, bob_n;
	logic [11:0] paddr;
	logic [31:0] pwdata, prdata, q, seed;
	logic [15:0] va, vb;
	logic [13:0] wa, wb;
	logic [14:0] cap_h, cap_l, xo;
	logic [15:0] cn [7] = '{16'h0000, 16'h1FFF, 16'hE000, 16'h2000,
		16'hDFFF, 16'h0001, 16'hFFFF};
	int err_count, checked, i, f;
	// short sleep recovery keeps the run brief
	dfm_output_stage #(.SLEEP_SETTLE_CYC(20)) uut (.pclk(pclk),
		.presetn(presetn), .paddr(paddr), .psel(psel), .penable(penable),
		.pwrite(pwrite), .pwdata(pwdata), .prdata(prdata), .pready(pready),
		.pslverr(pslverr), .sample_clock_chan_a(sclk),
		.sample_clock_chan_b(sclk), .conv_result_chan_a(va),
		.conv_result_chan_b(vb), .output_drive_enable_n_chan_a(oa_n),
		.output_drive_enable_n_chan_b(ob_n), .power_down_select_chan_a(pda),
		.power_down_select_chan_b(pdb), .bus_swap_select(swp),
		.output_bus_a_word(wa), .range_exceeded_flag_bus_a(fa),
		.output_bus_a_oe_n(boa_n), .output_bus_b_word(wb),
		.range_exceeded_flag_bus_b(fb), .output_bus_b_oe_n(bob_n));
	// capture logic on bus a, strobed by the swap select
	dfm_capture_model cap (.pclk(pclk), .strobe(swp), .word(wa), .flag(fa),
		.oe_n(boa_n), .cap_hi_ff(cap_h), .cap_lo_ff(cap_l));
	initial begin
		pclk = 1'b0;
		forever #50 pclk = ~pclk;
	end
	// hang guard, far beyond the few thousand cycles expected
	initial begin
		repeat (20000) @(posedge pclk);
		err_count++;
		complete_run();
	end
	task automatic complete_run();
		$display("errors %0d checks %0d", err_count, checked);
		if (err_count == 0 && checked > 0) begin
			$display("Result: passed");
		end else begin
			$display("Result: failed");
		end
		$finish;
	endtask : complete_run
	function automatic logic [31:0] rnd();
		seed = seed ^ (seed << 13);
		seed = seed ^ (seed >> 17);
		seed = seed ^ (seed << 5);
		return seed;
	endfunction : rnd
	// expected flag and word for one conversion value
	function automatic logic [14:0] code(input logic [15:0] v,
		input logic tc);
		logic [14:0] r;
		r = {1'b0, v[13:0] ^ 14'h2000};
		if ($signed(v) > 16'sh1FFF) r = {1'b1, 14'h3FFF};
		if ($signed(v) < 16'shE000) r = 15'h4000;
		if (tc) r[13] = ~r[13];
		return r;
	endfunction : code
	task automatic cmp(input logic [31:0] got, input logic [31:0] exp);
		checked++;
		if (got !== exp) begin
			err_count++;
			$display("[ERR] %0t got %h expected %h", $time, got, exp);
		end
	endtask : cmp
	// one apb transfer, held until pready is seen high
	task automatic apb(input logic w, input logic [11:0] a,
		input logic [31:0] d);
		@(posedge pclk);
		psel <= 1'b1;
		penable <= 1'b0;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'b1;
		do @(posedge pclk); while (pready !== 1'b1);
		q = prdata;
		e = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask : apb
	// sample edges on both channels, swap follows them when interleaving
	task automatic samp(input int n);
		repeat (n) begin
			@(posedge pclk);
			sclk <= 1'b1;
			if (il) swp <= 1'b1;
			repeat (3) @(posedge pclk);
			sclk <= 1'b0;
			if (il) swp <= 1'b0;
			repeat (2) @(posedge pclk);
		end
	endtask : samp
	task automatic chk(input logic tc);
		logic [14:0] xa;
		logic [14:0] xb;
		xa = swp ? code(va, tc) : code(vb, tc);
		xb = swp ? code(vb, tc) : code(va, tc);
		cmp({fa, wa}, xa);
		cmp({fb, wb}, xb);
	endtask : chk
	initial begin
		seed = 32'h0000C75E;
		err_count = 0;
		checked = 0;
		{psel, penable, pwrite, sclk, il, oa_n, ob_n, pda, pdb} = 9'h000;
		paddr = 12'h000;
		pwdata = 32'h0;
		va = 16'h0000;
		vb = 16'h0000;
		swp = 1'b1;
		presetn = 1'b0;
		repeat (16) @(posedge pclk);
		presetn <= 1'b1;
		// reset values, then an unmapped word
		apb(1'b0, 12'h000, 32'h0);
		cmp(q, 32'h0);
		apb(1'b0, 12'h004, 32'h0);
		cmp(q, 32'h0);
		apb(1'b0, 12'h0FC, 32'h0);
		cmp({31'h0, e}, 32'h1);
		// every format level, corner codes then random values
		for (f = 0; f < 4; f++) begin
			apb(1'b1, 12'h000, 32'(f));
			apb(1'b0, 12'h004, 32'h0);
			// format table per level: 00, 01, 11, 10 as {twos, stabilizer}
			cmp(q[8:7], (32'hB4 >> (2 * f)) & 32'h3);
			for (i = 0; i < 10; i++) begin
				q = rnd();
				if (i[1]) q[15:14] = {2{q[13]}};
				va <= (i < 7) ? cn[i] : q[15:0];
				vb <= q[31:16];
				swp <= i[0];
				samp(6);
				repeat (2) @(posedge pclk);
				chk(f[1]);
			end
		end
		// a new value emerges only at the fifth sample edge
		xo = code(va, 1'b1);
		va <= 16'h0123;
		samp(4);
		repeat (2) @(posedge pclk);
		cmp({fa, wa}, xo);
		samp(1);
		repeat (2) @(posedge pclk);
		chk(1'b1);
		// bus a released by its own enable between bursts only
		oa_n <= 1'b1;
		repeat (3) @(posedge pclk);
		cmp({boa_n, fa, wa}, 32'h8000);
		cmp(bob_n, 32'h0);
		oa_n <= 1'b0;
		// nap on channel a, recovery counted in sample edges
		apb(1'b1, 12'h000, 32'h1);
		pda <= 1'b1;
		repeat (3) @(posedge pclk);
		apb(1'b0, 12'h004, 32'h0);
		cmp(q[5:0], 32'h1);
		cmp({boa_n, fa, wa}, 32'h8000);
		cmp(bob_n, 32'h0);
		pda <= 1'b0;
		repeat (2) @(posedge pclk);
		apb(1'b0, 12'h004, 32'h0);
		cmp(q[2:0], 32'h3);
		samp(99);
		apb(1'b0, 12'h004, 32'h0);
		cmp(q[2:0], 32'h3);
		samp(1);
		repeat (2) @(posedge pclk);
		apb(1'b0, 12'h004, 32'h0);
		cmp(q[2:0], 32'h0);
		cmp(q[6], 32'h1);
		// sleep on channel a, recovery counted in clock cycles
		oa_n <= 1'b1;
		pda <= 1'b1;
		repeat (3) @(posedge pclk);
		apb(1'b0, 12'h004, 32'h0);
		cmp(q[2:0], 32'h2);
		cmp({boa_n, fa, wa}, 32'h8000);
		pda <= 1'b0;
		repeat (2) @(posedge pclk);
		apb(1'b0, 12'h004, 32'h0);
		cmp(q[2:0], 32'h4);
		repeat (25) @(posedge pclk);
		apb(1'b0, 12'h004, 32'h0);
		cmp(q[2:0], 32'h0);
		// a long clock stop drops the stabilizer lock
		repeat (1000) @(posedge pclk);
		apb(1'b0, 12'h004, 32'h0);
		cmp(q[7:6], 32'h2);
		oa_n <= 1'b0;
		// both channels interleaved on bus a, bus b switched off
		va <= 16'h2100;
		vb <= 16'h0042;
		samp(6);
		il <= 1'b1;
		ob_n <= 1'b1;
		samp(2);
		// routing lags the swap by one clock, let the low phase settle
		repeat (2) @(posedge pclk);
		cmp(cap_h, code(va, 1'b0));
		cmp(cap_l, code(vb, 1'b0));
		cmp(bob_n, 32'h1);
		complete_run();
	end
endmodule : dual_adc_output_format_mux_tb_top
`default_nettype wire
